// *** ccrb_bank.sv ***
// charger command register bank with word-wide serial slave, watchdog and learn control
`timescale 1ns/1ps
`include "ccrb_cfg.svh"

// How it works
// [R1] six word registers chosen by command byte
// [R2] two identity words fixed, writes ignored
// [R3] option register read/write, resets 0x7904
// [R4] charge current 7 bits, voltage 11 bits, zero
// [R5] input current 6 bits, resets 0x1000
// [R6] bit 15 picks long adapter deglitch
// [R7] long deglitch only after switch cycled once
// [R8] bus works only with supply and detect
// [R9] bits 14:13 pick watchdog period
// [R10] no setting write in period suspends charge
// [R11] setting write after expiry resumes charge
// [R12] bits 12:11 pick depletion threshold
// [R13] depletion in learn returns to adapter
// [R14] bits 10:9 frequency adjust direction/enable
// [R15] bits 8:7 high-side short threshold
// [R16] setting bit 6 starts battery discharge
// [R17] depletion clears bit 6 by itself
// [R18] clearing bit 6 stops discharge
// [R19] bit 5 selects current monitor source
// [R20] bits 2:1 input overcurrent trip level
// [R21] bit 0 inhibits charging
// [R22] slave only, address 0001001
// [R23] setting write restarts watchdog
// [R24] bits 4:3 read zero, code 11 dropped
module ccrb_bank #(
    parameter logic [15:0] MAKER_ID = 16'h5A01,  // arbitrary value
    parameter logic [15:0] PART_ID = 16'h00C3,   // arbitrary value
    parameter logic [35:0] WD1_CYC = `CCRB_WD1_CYC,  // shortest watchdog
    parameter logic [35:0] WD2_CYC = `CCRB_WD2_CYC,  // middle watchdog
    parameter logic [35:0] WD3_CYC = `CCRB_WD3_CYC   // longest watchdog
) (
    input wire logic core_clk,  // device clock
    input wire logic rst,  // async reset, high
    input wire logic smb_clk_in,  // bus clock pin level
    input wire logic smb_data_in,  // bus data pin level
    output logic smb_data_out,  // data pin drive value
    output logic smb_data_oe,  // data pin pulled low when high
    input wire logic supply_valid_threshold,  // supply above lockout
    input wire logic adapter_detect_input,  // detect above threshold
    input wire logic battery_depleted,  // depletion comparator
    output ccrb_pkg::ccrb_cfg_t cfg_out,  // stored settings
    output logic adapter_path_switch,  // adapter switch on
    output logic battery_path_switch,  // battery switch on
    output logic deglitch_long_sel,  // long adapter deglitch active
    output logic charge_enable,  // charging permitted
    output logic watchdog_suspended  // charging held by watchdog
);
    import ccrb_pkg::*;

    // =========================================================
    // helpers

    // read decode of the six commands
    function automatic logic [15:0] read_word(input logic [7:0] c, input ccrb_cfg_t g);
        logic [15:0] v;
        v = 16'h0000;
        case (c)
            `CCRB_CMD_OPT: v = g.opt;
            `CCRB_CMD_CC: v = g.cc;
            `CCRB_CMD_CV: v = g.cv;
            `CCRB_CMD_IC: v = g.ic;
            `CCRB_CMD_MAKER: v = MAKER_ID;  // see [R2]
            `CCRB_CMD_PART: v = PART_ID;  // see [R2]
            default: v = 16'h0000;  // unmapped reads zero
        endcase
        return v;
    endfunction

    // watchdog period from the mode field
    function automatic logic [35:0] wd_limit(input logic [1:0] m);
        logic [35:0] v;
        v = WD3_CYC;
        case (m)
            2'h1: v = WD1_CYC;
            2'h2: v = WD2_CYC;
            default: v = WD3_CYC;
        endcase
        return v;
    endfunction

    // =========================================================
    // state
    ccrb_state_t s_reg;  // registered state
    ccrb_state_t s_next;  // next state
    logic wr_fire;  // write word committed this cycle
    logic bus_en;  // bus communication allowed
    logic scl_rise;  // clock edge seen
    logic scl_fall;  // clock edge seen
    logic start_det;  // start or repeated start
    logic stop_det;  // stop
    logic depl;  // synchronised depletion
    logic [1:0] wd_mode;  // watchdog field
    logic [7:0] txbyte;  // byte being sent

    assign bus_en = s_reg.sync_s[2] & s_reg.sync_s[3];  // see [R8]
    assign depl = s_reg.sync_s[4];
    assign scl_rise = s_reg.sync_s[0] & ~s_reg.scl_p;
    assign scl_fall = ~s_reg.sync_s[0] & s_reg.scl_p;
    // data moves while clock high only for start and stop
    assign start_det = s_reg.sync_s[0] & s_reg.scl_p & s_reg.sda_p & ~s_reg.sync_s[1];
    assign stop_det = s_reg.sync_s[0] & s_reg.scl_p & ~s_reg.sda_p & s_reg.sync_s[1];
    assign wd_mode = s_reg.cfg.opt[`CCRB_OPT_WD_HI:`CCRB_OPT_WD_LO];
    assign txbyte = (s_reg.st == CCRB_RLO) ? s_reg.rdat[7:0] : s_reg.rdat[15:8];

    // =========================================================
    // next-state logic
    always_comb begin
        s_next = s_reg;
        wr_fire = 1'b0;
        // two-stage pin synchronisers, edge history from the second stage
        s_next.sync_m = {battery_depleted, adapter_detect_input, supply_valid_threshold,
                         smb_data_in, smb_clk_in};
        s_next.sync_s = s_reg.sync_m;
        s_next.scl_p = s_reg.sync_s[0];
        s_next.sda_p = s_reg.sync_s[1];

        // bus engine
        if (!bus_en) begin
            // disabled bus: silent, no acknowledge
            s_next.st = CCRB_IDLE;  // see [R8]
            s_next.oe = 1'b0;
            s_next.bcnt = 4'h0;
        end else if (start_det) begin
            // command byte survives a repeated start for reads
            s_next.st = CCRB_ADDR;
            s_next.bcnt = 4'h0;
            s_next.oe = 1'b0;
        end else if (stop_det) begin
            s_next.st = CCRB_IDLE;
            s_next.oe = 1'b0;
        end else if (s_reg.st == CCRB_RLO || s_reg.st == CCRB_RHI) begin
            // transmit: bits change on falling clock
            if (scl_rise && s_reg.bcnt == 4'h9) begin
                s_next.ackd = ~s_reg.sync_s[1];
            end else if (scl_fall) begin
                if (s_reg.bcnt < 4'h8) begin
                    s_next.oe = ~txbyte[3'(4'h7 - s_reg.bcnt)];
                    s_next.bcnt = s_reg.bcnt + 4'h1;
                end else if (s_reg.bcnt == 4'h8) begin
                    s_next.oe = 1'b0;  // master acknowledge slot
                    s_next.bcnt = 4'h9;
                end else if (s_reg.st == CCRB_RLO && s_reg.ackd) begin
                    s_next.st = CCRB_RHI;
                    s_next.oe = ~s_reg.rdat[15];
                    s_next.bcnt = 4'h1;
                end else begin
                    s_next.st = CCRB_IDLE;  // nack or word done
                    s_next.oe = 1'b0;
                end
            end
        end else if (s_reg.st != CCRB_IDLE) begin
            // receive: sample on rising clock
            if (scl_rise && s_reg.bcnt < 4'h8) begin
                s_next.sh = {s_reg.sh[6:0], s_reg.sync_s[1]};
                s_next.bcnt = s_reg.bcnt + 4'h1;
            end else if (scl_fall && s_reg.bcnt == 4'h8) begin
                // byte complete: decide acknowledge
                s_next.bcnt = 4'h9;
                s_next.oe = 1'b1;
                case (s_reg.st)
                    CCRB_ADDR: begin
                        if (s_reg.sh[7:1] != `CCRB_SLAVE_ADDR) begin
                            s_next.st = CCRB_IDLE;  // see [R22]
                            s_next.oe = 1'b0;
                        end
                        s_next.rdat = read_word(s_reg.cmd, s_reg.cfg);  // see [R1]
                    end
                    CCRB_CMD: s_next.cmd = s_reg.sh;
                    CCRB_WLO: s_next.lo = s_reg.sh;
                    CCRB_WHI: wr_fire = 1'b1;
                    default: s_next.oe = 1'b0;
                endcase
            end else if (scl_fall && s_reg.bcnt == 4'h9) begin
                // acknowledge slot over
                s_next.oe = 1'b0;
                s_next.bcnt = 4'h0;
                case (s_reg.st)
                    CCRB_ADDR: begin
                        if (s_reg.sh[0]) begin
                            s_next.st = CCRB_RLO;
                            s_next.oe = ~s_reg.rdat[7];
                            s_next.bcnt = 4'h1;
                        end else begin
                            s_next.st = CCRB_CMD;
                        end
                    end
                    CCRB_CMD: s_next.st = CCRB_WLO;
                    CCRB_WLO: s_next.st = CCRB_WHI;
                    default: s_next.st = CCRB_IDLE;  // extra bytes ignored
                endcase
            end
        end

        // learn ends on depletion; a host write below still wins
        if (s_reg.cfg.opt[`CCRB_OPT_LEARN] && depl) begin
            s_next.cfg.opt[`CCRB_OPT_LEARN] = 1'b0;  // see [R13] see [R17]
        end

        // watchdog: counts while enabled, holds at expiry
        if (wd_mode == 2'h0) begin
            s_next.wd_cnt = 36'h0;  // see [R9]
        end else if (s_reg.wd_cnt >= wd_limit(wd_mode)) begin
            s_next.wd_susp = 1'b1;  // see [R10]
        end else begin
            s_next.wd_cnt = s_reg.wd_cnt + 36'h1;
        end

        // committed write; identity commands fall through unchanged
        if (wr_fire) begin
            case (s_reg.cmd)
                `CCRB_CMD_OPT: s_next.cfg.opt = {s_reg.sh, s_reg.lo} & `CCRB_OPT_MASK;  // see [R3] see [R24]
                `CCRB_CMD_CC: begin
                    s_next.cfg.cc = {s_reg.sh, s_reg.lo} & `CCRB_CC_MASK;  // see [R4]
                    s_next.wd_cnt = 36'h0;  // see [R23]
                    s_next.wd_susp = 1'b0;  // see [R11]
                end
                `CCRB_CMD_CV: begin
                    s_next.cfg.cv = {s_reg.sh, s_reg.lo} & `CCRB_CV_MASK;  // see [R4]
                    s_next.wd_cnt = 36'h0;  // see [R23]
                    s_next.wd_susp = 1'b0;  // see [R11]
                end
                `CCRB_CMD_IC: s_next.cfg.ic = {s_reg.sh, s_reg.lo} & `CCRB_IC_MASK;  // see [R5]
                default: s_next.cfg = s_reg.cfg;  // see [R2]
            endcase
        end

        // adapter switch history for the deglitch choice
        if (adapter_path_switch) begin
            s_next.sw_seen = 1'b1;
        end else if (s_reg.sw_seen) begin
            s_next.cycled = 1'b1;  // see [R7]
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.st <= CCRB_IDLE;
            s_reg.cfg.opt <= `CCRB_OPT_RST;  // see [R3]
            s_reg.cfg.cc <= `CCRB_CC_RST;
            s_reg.cfg.cv <= `CCRB_CV_RST;
            s_reg.cfg.ic <= `CCRB_IC_RST;  // see [R5]
            s_reg.scl_p <= 1'b1;
            s_reg.sda_p <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // =========================================================
    // outputs, all decoded from registered state
    assign smb_data_out = 1'b0;  // open drain: only ever pulls low
    assign smb_data_oe = s_reg.oe;
    // see [R12] see [R14] see [R15] see [R19] see [R20]
    assign cfg_out = s_reg.cfg;  // fields feed the analog side as stored
    // learn hands the system to the battery; otherwise adapter when present
    assign battery_path_switch = s_reg.cfg.opt[`CCRB_OPT_LEARN] | ~s_reg.sync_s[3];  // see [R16]
    assign adapter_path_switch = ~battery_path_switch;  // see [R18]
    assign deglitch_long_sel = s_reg.cfg.opt[`CCRB_OPT_DGL_LONG] & s_reg.cycled;  // see [R6]
    assign charge_enable = ~s_reg.cfg.opt[`CCRB_OPT_INHIBIT] & ~s_reg.wd_susp;  // see [R21]
    assign watchdog_suspended = s_reg.wd_susp;

    // =========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence wr_setting_s;
        wr_fire && (s_reg.cmd == `CCRB_CMD_CC || s_reg.cmd == `CCRB_CMD_CV);
    endsequence

    sequence wd_expire_s;
        wd_mode != 2'h0 && s_reg.wd_cnt >= wd_limit(wd_mode) && !wr_fire;
    endsequence

    id_write_ign_a: assert property ( // see [R2]
        wr_fire && s_reg.cmd >= `CCRB_CMD_MAKER |=> $stable(s_reg.cfg))
        else $error("identity write changed a register");
    opt_write_a: assert property ( // see [R3]
        wr_fire && s_reg.cmd == `CCRB_CMD_OPT
        |=> s_reg.cfg.opt == ($past({s_reg.sh, s_reg.lo}) & `CCRB_OPT_MASK))
        else $error("option write not stored");
    cc_write_a: assert property ( // see [R4]
        wr_fire && s_reg.cmd == `CCRB_CMD_CC
        |=> s_reg.cfg.cc == ($past({s_reg.sh, s_reg.lo}) & `CCRB_CC_MASK))
        else $error("charge current write not stored");
    ic_bits_a: assert property ( // see [R5]
        (s_reg.cfg.ic & ~`CCRB_IC_MASK) == 16'h0000)
        else $error("input current holds unused bits");
    bus_gate_a: assert property ( // see [R8]
        !bus_en |=> s_reg.st == CCRB_IDLE && !smb_data_oe)
        else $error("bus active while disabled");
    wd_expire_a: assert property ( // see [R10]
        wd_expire_s |=> watchdog_suspended && !charge_enable)
        else $error("watchdog expiry did not suspend");
    wd_kick_a: assert property ( // see [R11]
        wr_setting_s |=> s_reg.wd_cnt == 36'h0 && !watchdog_suspended ##1 s_reg.wd_cnt <= 36'h1)
        else $error("setting write did not restart watchdog");
    learn_end_a: assert property ( // see [R17]
        s_reg.cfg.opt[`CCRB_OPT_LEARN] && depl && !wr_fire
        |=> !s_reg.cfg.opt[`CCRB_OPT_LEARN] && adapter_path_switch)
        else $error("learn not ended on depletion");
    learn_sw_a: assert property ( // see [R16]
        s_reg.cfg.opt[`CCRB_OPT_LEARN] |-> battery_path_switch && !adapter_path_switch)
        else $error("learn without battery path");
    long_dgl_a: assert property ( // see [R7]
        deglitch_long_sel |-> s_reg.cycled && s_reg.sw_seen)
        else $error("long deglitch before switch cycled");
    unused_bits_a: assert property ( // see [R24]
        cfg_out.opt[4:3] == 2'h0)
        else $error("option bits 4:3 not zero");
    addr_nack_a: assert property ( // see [R22]
        s_reg.st == CCRB_ADDR && scl_fall && s_reg.bcnt == 4'h8 && bus_en && !start_det
        && !stop_det && s_reg.sh[7:1] != `CCRB_SLAVE_ADDR |=> !smb_data_oe [*2])
        else $error("foreign address acknowledged");
endmodule

// *** ccrb_cfg.svh ***
// register map, reset values, field positions and timing constants of the charger command bank
`ifndef CCRB_CFG_SVH
`define CCRB_CFG_SVH

// =========================================================
// bus addressing
`define CCRB_SLAVE_ADDR 7'h09
`define CCRB_CMD_OPT 8'h12
`define CCRB_CMD_CC 8'h14
`define CCRB_CMD_CV 8'h15
`define CCRB_CMD_IC 8'h3F
`define CCRB_CMD_MAKER 8'hFE
`define CCRB_CMD_PART 8'hFF

// =========================================================
// reset values and writable-bit masks
`define CCRB_OPT_RST 16'h7904
`define CCRB_CC_RST 16'h0000
`define CCRB_CV_RST 16'h0000
`define CCRB_IC_RST 16'h1000
`define CCRB_OPT_MASK 16'hFFE7
`define CCRB_CC_MASK 16'h1FC0
`define CCRB_CV_MASK 16'h7FF0
`define CCRB_IC_MASK 16'h1F80

// =========================================================
// option field positions
`define CCRB_OPT_DGL_LONG 15
`define CCRB_OPT_WD_HI 14
`define CCRB_OPT_WD_LO 13
`define CCRB_OPT_LEARN 6
`define CCRB_OPT_INHIBIT 0

// =========================================================
// timing
`define CCRB_CLK_HZ 64'd200000000
`define CCRB_WD1_S 64'd44
`define CCRB_WD2_S 64'd88
`define CCRB_WD3_S 64'd175
`define CCRB_WD1_CYC 36'(`CCRB_WD1_S * `CCRB_CLK_HZ)
`define CCRB_WD2_CYC 36'(`CCRB_WD2_S * `CCRB_CLK_HZ)
`define CCRB_WD3_CYC 36'(`CCRB_WD3_S * `CCRB_CLK_HZ)

`endif

// *** ccrb_pkg.sv ***
// types shared by the charger command bank
package ccrb_pkg;
    // bus engine phases
    typedef enum logic [2:0] {
        CCRB_IDLE, CCRB_ADDR, CCRB_CMD, CCRB_WLO, CCRB_WHI, CCRB_RLO, CCRB_RHI
    } ccrb_st_t;

    // settings handed to the analog side
    typedef struct packed {
        logic [15:0] opt;  // option word
        logic [15:0] cc;   // charge current word
        logic [15:0] cv;   // charge voltage word
        logic [15:0] ic;   // input current word
    } ccrb_cfg_t;

    // whole module state
    typedef struct packed {
        ccrb_st_t st;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic [7:0] cmd;
        logic [7:0] lo;
        logic [15:0] rdat;
        logic ackd;
        logic oe;
        ccrb_cfg_t cfg;
        logic [35:0] wd_cnt;
        logic wd_susp;
        logic sw_seen;
        logic cycled;
        logic [4:0] sync_m;  // first stage: scl, sda, supply, detect, depleted
        logic [4:0] sync_s;  // second stage
        logic scl_p;
        logic sda_p;
    } ccrb_state_t;
endpackage

// *** ccrb_host.sv ***
// serial bus master model standing in for the embedded controller
`timescale 1ns/1ps
module ccrb_host (
    input wire logic core_clk,  // device clock, paces every change
    output logic smb_clk,  // bus clock, idle high
    output logic sda_low,  // high pulls the data wire low
    input wire logic sda_line  // resolved data wire level
);
    int stretch = 0;  // extra high-phase cycles, models a slow master

    // idle bus: both lines released to their pull-ups
    initial begin
        smb_clk = 1'b1;
        sda_low = 1'b0;
    end

    // ==========================================================
    // bit level
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // data moves only while clock is low; the phases stay well above the
    // synchroniser depth so no edge is lost inside the device
    task automatic bit_io(input logic b, output logic r);
        wt(4);
        sda_low <= ~b;
        wt(8);
        smb_clk <= 1'b1;
        wt(12 + stretch);
        r = sda_line;
        smb_clk <= 1'b0;
    endtask

    // start and repeated start share one shape
    task automatic start();
        wt(4);
        sda_low <= 1'b0;
        wt(8);
        smb_clk <= 1'b1;
        wt(8);
        sda_low <= 1'b1;
        wt(8);
        smb_clk <= 1'b0;
    endtask

    task automatic stop();
        wt(4);
        sda_low <= 1'b1;
        wt(8);
        smb_clk <= 1'b1;
        wt(8);
        sda_low <= 1'b0;
        wt(8);
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
                           output logic ao);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ai, ao);
    endtask

    // ==========================================================
    // word transfers, ack bits returned in order, 0 = acknowledged
    task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
                              input logic [15:0] dat, output logic [3:0] ack);
        logic [7:0] q;
        start();
        byte_io({adr, 1'b0}, 1'b1, q, ack[3]);
        byte_io(cmd, 1'b1, q, ack[2]);
        byte_io(dat[7:0], 1'b1, q, ack[1]);
        byte_io(dat[15:8], 1'b1, q, ack[0]);
        stop();
    endtask

    // low byte acked by us, high byte closed with a nack
    task automatic read_word(input logic [6:0] adr, input logic [7:0] cmd,
                             output logic [15:0] dat, output logic [3:0] ack);
        logic [7:0] q;
        logic n;
        start();
        byte_io({adr, 1'b0}, 1'b1, q, ack[3]);
        byte_io(cmd, 1'b1, q, ack[2]);
        start();
        byte_io({adr, 1'b1}, 1'b1, q, ack[1]);
        byte_io(8'hFF, 1'b0, dat[7:0], ack[0]);
        byte_io(8'hFF, 1'b1, dat[15:8], n);
        stop();
    endtask
endmodule

// *** ccrb_bank_tb.sv ***
// self-checking bench for the charger command bank
`timescale 1ns/1ps
`include "ccrb_cfg.svh"
module ccrb_bank_tb;
    import ccrb_pkg::*;
    // ==========================================================
    // constants, watchdog shortened so the run stays brief
    localparam int WDP[3] = '{3000, 6000, 12000};  // cycles per watchdog code
    localparam logic [1:0] WDM[3] = '{2'h1, 2'h2, 2'h3};  // watchdog codes
    localparam logic [15:0] MAKER = 16'h3C11;  // arbitrary value
    localparam logic [15:0] PART = 16'h0A72;  // arbitrary value
    localparam logic [7:0] CMDS[6] = '{8'h12, 8'h14, 8'h15, 8'h3F, 8'hFE, 8'hFF};
    localparam logic [15:0] RSTV[6] = '{16'h7904, 16'h0000, 16'h0000, 16'h1000, MAKER, PART};
    localparam logic [15:0] MASK[6] = '{16'hFFE7, 16'h1FC0, 16'h7FF0, 16'h1F80, MAKER, PART};
    logic core_clk, rst, smb_clk, sda_low, sda_line, smb_data_out, smb_data_oe;
    logic supply_valid_threshold, adapter_detect_input, battery_depleted;
    logic adapter_path_switch, battery_path_switch, deglitch_long_sel;
    logic charge_enable, watchdog_suspended;
    ccrb_cfg_t cfg_out;  // stored settings seen at the port
    logic [15:0] rd;  // last read word
    logic [3:0] ack;  // last ack pattern
    int errors = 0;
    int total_checks = 0;

    // open-drain data wire with pull-up: low if either party pulls
    assign sda_line = ~(sda_low | smb_data_oe);

    ccrb_bank #(.MAKER_ID(MAKER), .PART_ID(PART), .WD1_CYC(36'(WDP[0])),
                .WD2_CYC(36'(WDP[1])), .WD3_CYC(36'(WDP[2]))) DUT (
        .core_clk, .rst, .smb_clk_in(smb_clk), .smb_data_in(sda_line), .smb_data_out,
        .smb_data_oe, .supply_valid_threshold, .adapter_detect_input, .battery_depleted,
        .cfg_out, .adapter_path_switch, .battery_path_switch, .deglitch_long_sel,
        .charge_enable, .watchdog_suspended);
    ccrb_host host (.core_clk, .smb_clk, .sda_low, .sda_line);

    // 200 MHz device clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ==========================================================
    // compare, bus and closing tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.write_word(`CCRB_SLAVE_ADDR, c, d, ack);
        chk16("write ack", 16'h0000, {12'h000, ack});
    endtask
    task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
        host.read_word(`CCRB_SLAVE_ADDR, c, rd, ack);
        chk16("read ack", 16'h0000, {12'h000, ack});
        chk16("read data", e, rd);
    endtask
    task automatic finish_test();
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard, well beyond the expected run length
    initial begin
        cyc(90000);
        errors++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        supply_valid_threshold = 1'b1;
        adapter_detect_input = 1'b1;
        battery_depleted = 1'b0;
        cyc(10);
        rst <= 1'b0;
        cyc(10);
        chk1("charge enable", 1'b1, charge_enable);
        foreach (CMDS[i]) rdchk(CMDS[i], RSTV[i]);
        // long deglitch held off until the adapter switch has cycled
        wr(`CCRB_CMD_OPT, 16'hF904);
        chk1("long deglitch", 1'b0, deglitch_long_sel);
        wr(`CCRB_CMD_OPT, 16'hF944);
        chk1("battery switch", 1'b1, battery_path_switch);
        chk1("adapter switch", 1'b0, adapter_path_switch);
        chk1("long deglitch", 1'b1, deglitch_long_sel);
        battery_depleted <= 1'b1;
        cyc(8);
        chk16("learn end", 16'hF904, cfg_out.opt);
        chk1("battery switch", 1'b0, battery_path_switch);
        chk1("adapter switch", 1'b1, adapter_path_switch);
        battery_depleted <= 1'b0;
        cyc(8);
        wr(`CCRB_CMD_OPT, 16'hF944);
        wr(`CCRB_CMD_OPT, 16'hF904);
        chk1("battery switch", 1'b0, battery_path_switch);
        chk1("adapter switch", 1'b1, adapter_path_switch);
        // all ones into every register, read back what sticks
        foreach (CMDS[i]) begin
            wr(CMDS[i], 16'hFFFF);
            rdchk(CMDS[i], MASK[i]);
        end
        chk16("cfg current", 16'h1FC0, cfg_out.cc);
        chk1("charge enable", 1'b0, charge_enable);
        wr(`CCRB_CMD_OPT, 16'h0000);
        rdchk(`CCRB_CMD_OPT, 16'h0000);
        chk1("charge enable", 1'b1, charge_enable);
        // unknown command on a slow bus, foreign address, bus disabled
        host.stretch = 20;
        wr(8'h20, 16'h1234);
        rdchk(8'h20, 16'h0000);
        host.stretch = 0;
        host.write_word(7'h0A, `CCRB_CMD_CC, 16'h0040, ack);
        chk16("foreign ack", 16'h000F, {12'h000, ack});
        adapter_detect_input <= 1'b0;
        cyc(8);
        host.write_word(`CCRB_SLAVE_ADDR, `CCRB_CMD_CC, 16'h0040, ack);
        chk16("disabled ack", 16'h000F, {12'h000, ack});
        adapter_detect_input <= 1'b1;
        cyc(8);
        rdchk(`CCRB_CMD_CC, 16'h1FC0);
        // each watchdog period: quiet until just short, suspended just after
        foreach (WDP[i]) begin
            wr(`CCRB_CMD_OPT, {1'b0, WDM[i], 13'h0000});
            wr(`CCRB_CMD_CC, 16'h0040);
            cyc(WDP[i] - 100);
            chk1("suspended", 1'b0, watchdog_suspended);
            cyc(200);
            chk1("suspended", 1'b1, watchdog_suspended);
            chk1("charge enable", 1'b0, charge_enable);
            wr(`CCRB_CMD_CV, 16'h1000);
            chk1("charge enable", 1'b1, charge_enable);
        end
        // a voltage write just before expiry restarts the shortest period
        wr(`CCRB_CMD_OPT, 16'h2000);
        wr(`CCRB_CMD_CC, 16'h0080);
        cyc(2000);
        wr(`CCRB_CMD_CV, 16'h2000);
        cyc(2000);
        chk1("suspended", 1'b0, watchdog_suspended);
        cyc(1200);
        chk1("suspended", 1'b1, watchdog_suspended);
        finish_test();
    end
endmodule
